/* rtl/dcesm_pkg.sv */
// Constants for the DMA channel event capture and sync map
package dcesm_pkg;
   localparam int DCESM_NCH = 64;
   localparam int DCESM_HALF = 32;
   localparam int DCESM_PRIO_W = 3;
   localparam int CH_HOST = 0;
   localparam int CH_TIMER0 = 1;
   localparam int CH_TIMER1 = 2;
   localparam int CH_SDRAM_A = 3;
   localparam int CH_GPIO_HI = 4;
   localparam int CH_GPIO_LO = 8;
   localparam int CH_SERIAL = 12;
   localparam int CH_SERIAL2 = 17;
   localparam int CH_TIMER2 = 19;
   localparam int CH_SDRAM_B = 20;
   localparam int CH_VITERBI_RX = 28;
   localparam int CH_CELL_RX = 32;
   localparam int CH_CELL_TX = 40;
   localparam int CH_GPIO_EXT = 48;
   localparam logic [63:0] DCESM_CAPTURE_RESET = 64'h0000000000000000;
endpackage

/* rtl/dcesm_evt_if.sv */
// Interface carrying raw channel events into the capture register
`timescale 1ns/10ps
interface dcesm_evt_if;
   logic [63:0] chanEvent;
   logic [63:0] serviceClear;
   logic [63:0] captured;
   modport map (output chanEvent, output serviceClear, input captured);
   modport cap (input chanEvent, input serviceClear, output captured);
endinterface

/* rtl/dcesm_capture.sv */
// Sticky event capture register for all channels
`timescale 1ns/10ps
module dcesm_capture
   import dcesm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   dcesm_evt_if.cap evt
);
   logic [63:0] capture_r;
   logic [63:0] capture_nxt;
   // Set wins over clear so an event in the clear cycle is kept
   assign capture_nxt = (capture_r & ~evt.serviceClear) | evt.chanEvent;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         capture_r <= DCESM_CAPTURE_RESET;
      end else begin
         capture_r <= capture_nxt;
      end
   end
   assign evt.captured = capture_r;
endmodule // dcesm_capture

/* rtl/dcesm_event_map.sv */
// Fixed event-to-channel map, capture, enable gating and priority lookup
`timescale 1ns/10ps
module dcesm_event_map
   import dcesm_pkg::*;
#(
   parameter bit HAS_DECODERS = 1'b1,
   parameter bit HAS_PCI_CELL = 1'b1,
   parameter int PRIO_W = DCESM_PRIO_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hostBusIrq,
   input wire logic timer0_irq,
   input wire logic timer1_irq,
   input wire logic timer2_irq,
   input wire logic sdram_refresh_a_irq,
   input wire logic sdram_refresh_b_irq,
   input wire logic [15:0] gpioEvent,
   input wire logic [3:0] extPinEvent,
   input wire logic serial0_tx_event,
   input wire logic serial0_rx_event,
   input wire logic serial1TxEvent,
   input wire logic serial1RxEvent,
   input wire logic serial2_tx_event,
   input wire logic serial2_rx_event,
   input wire logic viterbi_rx_event,
   input wire logic cell_rx_event,
   input wire logic cell_tx_event,
   input wire logic [63:0] chainEvent,
   input wire logic [31:0] event_enable_low,
   input wire logic [31:0] event_enable_high,
   input wire logic [31:0] clearLow,
   input wire logic [31:0] clearHigh,
   input wire logic serviceValid,
   input wire logic [5:0] serviceChannel,
   input wire logic prioWrite,
   input wire logic [5:0] prioWriteChannel,
   input wire logic [PRIO_W-1:0] prioWriteData,
   output logic [31:0] event_capture_low,
   output logic [31:0] event_capture_high,
   output logic [63:0] pendingRequest,
   output logic requestValid,
   output logic [5:0] requestChannel,
   output logic [PRIO_W-1:0] requestPriority
);
   dcesm_evt_if evt ();
   logic [63:0] peripheralEvent;
   logic [63:0] serviceOneHot;
   logic [63:0] pendingNow;
   logic [PRIO_W-1:0] prioRam [DCESM_NCH];
   logic [5:0] pickChannel;
   logic pickValid;
   logic [PRIO_W-1:0] pickPrio;
   logic [5:0] requestChannel_r;
   logic [PRIO_W-1:0] requestPriority_r;
   logic requestValid_r;
   logic [63:0] captureOld;
   logic [63:0] liveChannels;
   logic [63:0] liveEvent;
   logic [DCESM_HALF-1:0] pendLow;
   logic [DCESM_HALF-1:0] pendHigh;
   logic pendLowAny;
   logic pendHighAny;
   logic [4:0] lowIdx;
   logic [4:0] highIdx;

   // Lowest set bit of one half; both halves share this encoder
   function automatic logic [4:0] lowestIndex(input logic [DCESM_HALF-1:0] bits);
      logic [4:0] idx;
      idx = 5'h00;
      for (int k = DCESM_HALF - 1; k >= 0; k--) begin
         if (bits[k]) begin
            idx = 5'(k);
         end
      end
      return idx;
   endfunction

   // Channels that own a live source on this variant; all others can be set only by chainEvent
   function automatic logic [63:0] sourcedChannels(input bit withDecoders, input bit withCell);
      logic [63:0] mask;
      mask = '0;
      mask[CH_HOST] = 1'b1;
      mask[CH_TIMER0] = 1'b1;
      mask[CH_TIMER1] = 1'b1;
      mask[CH_SDRAM_A] = 1'b1;
      mask[CH_GPIO_HI +: 4] = 4'hF;
      mask[CH_GPIO_LO +: 4] = 4'hF;
      mask[CH_SERIAL +: 4] = 4'hF;
      mask[CH_SERIAL2 +: 2] = 2'h3;
      mask[CH_TIMER2] = 1'b1;
      mask[CH_SDRAM_B] = 1'b1;
      mask[CH_VITERBI_RX] = withDecoders;
      mask[CH_CELL_RX] = withCell;
      mask[CH_CELL_TX] = withCell;
      mask[CH_GPIO_EXT +: 8] = 8'hFF;
      return mask;
   endfunction

   // Second guard: a stray wire onto an empty channel is dropped here
   assign liveChannels = sourcedChannels(HAS_DECODERS, HAS_PCI_CELL);

   // Hard-wired map; no register steers it, so software cannot reroute
   always_comb begin
      peripheralEvent = '0;
      peripheralEvent[CH_HOST] = hostBusIrq;
      peripheralEvent[CH_TIMER0] = timer0_irq;
      peripheralEvent[CH_TIMER1] = timer1_irq;
      peripheralEvent[CH_SDRAM_A] = sdram_refresh_a_irq;
      peripheralEvent[CH_GPIO_HI +: 4] = gpioEvent[7:4] | extPinEvent;
      peripheralEvent[CH_GPIO_LO +: 4] = gpioEvent[3:0];
      peripheralEvent[CH_SERIAL +: 4] = {serial1RxEvent, serial1TxEvent,
                                         serial0_rx_event, serial0_tx_event};
      peripheralEvent[CH_SERIAL2 +: 2] = {serial2_rx_event, serial2_tx_event};
      peripheralEvent[CH_TIMER2] = timer2_irq;
      peripheralEvent[CH_SDRAM_B] = sdram_refresh_b_irq;
      peripheralEvent[CH_VITERBI_RX] = HAS_DECODERS & viterbi_rx_event;
      peripheralEvent[CH_CELL_RX] = HAS_PCI_CELL & cell_rx_event;
      peripheralEvent[CH_CELL_TX] = HAS_PCI_CELL & cell_tx_event;
      peripheralEvent[CH_GPIO_EXT +: 8] = gpioEvent[15:8];
      // Host interrupt is not gated by HAS_PCI_CELL; without PCI only the cell RX and TX channels go silent
   end
   assign liveEvent = peripheralEvent & liveChannels;

   assign serviceOneHot = serviceValid ? (64'h0000000000000001 << serviceChannel) : 64'h0000000000000000;
   assign evt.chanEvent = liveEvent | chainEvent;
   assign evt.serviceClear = serviceOneHot | {clearHigh, clearLow};
   assign captureOld = evt.captured;

   dcesm_capture u_capture (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .evt(evt)
   );

   assign event_capture_low = captureOld[31:0];
   assign event_capture_high = captureOld[63:32];
   // Enable only gates the request, never the latch
   assign pendingNow = captureOld & {event_enable_high, event_enable_low};
   assign pendingRequest = pendingNow;

   // Lowest pending channel wins the pick; two half encoders keep the chain short
   assign pendLow = pendingNow[DCESM_HALF-1:0];
   assign pendHigh = pendingNow[DCESM_NCH-1:DCESM_HALF];
   assign pendLowAny = |pendLow;
   assign pendHighAny = |pendHigh;
   assign lowIdx = lowestIndex(pendLow);
   assign highIdx = lowestIndex(pendHigh);
   assign pickValid = pendLowAny | pendHighAny;
   assign pickChannel = pendLowAny ? {1'b0, lowIdx} : (pendHighAny ? {1'b1, highIdx} : 6'h00);
   assign pickPrio = prioRam[pickChannel];

   always_ff @(posedge clk_sys) begin
      if (prioWrite) begin
         prioRam[prioWriteChannel] <= prioWriteData;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         requestValid_r <= 1'b0;
         requestChannel_r <= 6'h00;
         requestPriority_r <= '0;
      end else begin
         requestValid_r <= pickValid;
         requestChannel_r <= pickChannel;
         requestPriority_r <= pickValid ? pickPrio : '0;
      end
   end
   assign requestValid = requestValid_r;
   assign requestChannel = requestChannel_r;
   assign requestPriority = requestPriority_r;
endmodule // dcesm_event_map

/* tb/dcesm_event_map_chk.sv */
// Port assertions for the event map
`timescale 1ns/10ps
module dcesm_event_map_chk(input wire logic clk_sys, resetn, timer0_irq, timer2_irq, viterbi_rx_event,
   cell_rx_event, serviceValid, requestValid, input wire logic [15:0] gpioEvent,
   input wire logic [63:0] pendingRequest, input wire logic [31:0] event_enable_low, event_enable_high,
   clearLow, event_capture_low, event_capture_high);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_t0; timer0_irq |=> event_capture_low[1]; endproperty
   a_t0: assert property (p_t0) else $error("timer0 lost");
   property p_gp; gpioEvent[0] |=> event_capture_low[8]; endproperty
   a_gp: assert property (p_gp) else $error("gpio0 lost");
   property p_t2; timer2_irq |=> event_capture_low[19]; endproperty
   a_t2: assert property (p_t2) else $error("timer2 lost");
   property p_vit; viterbi_rx_event |=> event_capture_low[28]; endproperty
   a_vit: assert property (p_vit) else $error("decoder lost");
   property p_cell; cell_rx_event |=> event_capture_high[0]; endproperty
   a_cell: assert property (p_cell) else $error("cell rx lost");
   property p_pend; pendingRequest == {event_capture_high & event_enable_high,
      event_capture_low & event_enable_low}; endproperty
   a_pend: assert property (p_pend) else $error("bad pending");
   property p_stk; !serviceValid && clearLow == 0 |=>
      (event_capture_low & $past(event_capture_low)) == $past(event_capture_low); endproperty
   a_stk: assert property (p_stk) else $error("bit dropped");
   // Pick is registered, so it trails pending by one edge
   property p_req; requestValid == ($past(pendingRequest) != 0); endproperty
   a_req: assert property (p_req) else $error("bad request");
   c_req: cover property (requestValid);
   c_svc: cover property (serviceValid);
   c_clr: cover property (clearLow != 0);
endmodule // dcesm_event_map_chk
bind dcesm_event_map dcesm_event_map_chk dcesm_event_map_chk_inst (.*);

/* tb/dcesm_periph_model.sv */
// Peripheral event sources feeding the event map
`timescale 1ns/10ps
module dcesm_periph_model(input wire logic en, input wire logic [63:0] rnd, output logic [34:0] ev);
   // Two words ANDed keep most sources quiet
   assign ev = en ? rnd[34:0] & rnd[63:29] : '0;
endmodule // dcesm_periph_model

/* tb/testbench.sv */
// Self-checking bench for the event map
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
   logic clk_sys = 0, resetn = 0, en = 0, serviceValid = 0, prioWrite = 0, requestValid;
   logic hostBusIrq, timer0_irq, timer1_irq, timer2_irq, sdram_refresh_a_irq, sdram_refresh_b_irq;
   logic serial0_tx_event, serial0_rx_event, serial1TxEvent, serial1RxEvent, serial2_tx_event;
   logic serial2_rx_event, viterbi_rx_event, cell_rx_event, cell_tx_event;
   logic [15:0] gpioEvent;
   logic [3:0] extPinEvent;
   logic [34:0] ev;
   logic [63:0] chainEvent = 0, rnd = 0, pendingRequest, expAll, pnd;
   logic [31:0] event_enable_low = 0, event_enable_high = 0, clearLow = 0, clearHigh = 0, st = 82;
   logic [31:0] event_capture_low, event_capture_high;
   logic [5:0] serviceChannel = 0, prioWriteChannel = 0, requestChannel, low;
   logic [2:0] prioWriteData = 0, requestPriority, pr [64];
   int fails = 0, checks_done = 0, cyc = 0;
   assign {hostBusIrq, timer0_irq, timer1_irq, sdram_refresh_a_irq, timer2_irq, sdram_refresh_b_irq,
      serial0_tx_event, serial0_rx_event, serial1TxEvent, serial1RxEvent, serial2_tx_event, serial2_rx_event,
      viterbi_rx_event, cell_rx_event, cell_tx_event, gpioEvent, extPinEvent} = ev;
   dcesm_event_map dcesm_event_map_inst (.*);
   dcesm_periph_model dcesm_periph_model_inst (.*);
   function logic [31:0] xs();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction
   function logic [63:0] mapEv();
      mapEv = chainEvent;
      mapEv[3:0] |= {sdram_refresh_a_irq, timer1_irq, timer0_irq, hostBusIrq};
      mapEv[11:4] |= {gpioEvent[3:0], gpioEvent[7:4] | extPinEvent};
      mapEv[20:12] |= {sdram_refresh_b_irq, timer2_irq, serial2_rx_event, serial2_tx_event, 1'b0,
         serial1RxEvent, serial1TxEvent, serial0_rx_event, serial0_tx_event};
      mapEv[28] |= viterbi_rx_event;
      mapEv[40] |= cell_tx_event;
      mapEv[32] |= cell_rx_event;
      mapEv[55:48] |= gpioEvent[15:8];
   endfunction
   task step();
      @(posedge clk_sys);
      #1;
   endtask
   task results();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 2000) begin
      fails++;
      results();
   end
   initial begin
      repeat (16) step();
      resetn = 1;
      for (int i = 0; i < 64; i++) begin
         prioWrite = 1;
         prioWriteChannel = 6'(i);
         prioWriteData = 3'(xs());
         pr[i] = prioWriteData;
         step();
      end
      prioWrite = 0;
      // First pass fires every source at once
      for (int i = 0; i < 60; i++) begin
         clearLow = '1;
         clearHigh = '1;
         step();
         clearLow = 0;
         clearHigh = 0;
         rnd = i ? {xs(), xs()} : '1;
         chainEvent = i ? {xs() & xs(), xs() & xs()} : '1;
         event_enable_low = xs();
         event_enable_high = xs();
         en = 1;
         #1 expAll = mapEv();
         step();
         `CHK("capture", expAll, {event_capture_high, event_capture_low})
         pnd = expAll & {event_enable_high, event_enable_low};
         `CHK("pending", pnd, pendingRequest)
         for (int c = 63; c >= 0; c--) if (pnd[c]) low = 6'(c);
         en = 0;
         chainEvent = 0;
         serviceValid = 1;
         serviceChannel = 6'(xs());
         expAll[serviceChannel] = 0;
         step();
         serviceValid = 0;
         `CHK("after service", expAll, {event_capture_high, event_capture_low})
         `CHK("req valid", pnd != 0, requestValid)
         if (pnd != 0) `CHK("req chan", low, requestChannel)
         if (pnd != 0) `CHK("req prio", pr[low], requestPriority)
      end
      results();
   end
endmodule // testbench
